// ### verilog/tcam_prog_pkg.sv
package tcam_prog_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] OFS_COMMIT      = 12'h000; // rule_commit_control
	localparam logic [11:0] OFS_BLOCKS      = 12'h004; // blocks given to the prefix tcam
	localparam logic [11:0] OFS_LOOKUP      = 12'h008; // lookup start and target
	localparam logic [11:0] OFS_KEY0        = 12'h00C; // lookup key bits 31:0
	localparam logic [11:0] OFS_KEY1        = 12'h010; // lookup key bits 63:32
	localparam logic [11:0] OFS_RESULT      = 12'h014; // lookup status
	localparam logic [11:0] OFS_COUNTER     = 12'h018; // staging hit counter
	localparam logic [11:0] OFS_KEYW        = 12'h040; // staging_key_words base
	localparam logic [11:0] OFS_CAREW       = 12'h060; // staging_care_words base
	localparam logic [11:0] OFS_RESW        = 12'h080; // staging_result_words base
	localparam int          KEY_WORDS       = 2;
	localparam int          RES_WORDS       = 9;

	////////////////////////////////////////////////////////////////////////////////
	// rule_commit_control fields
	localparam int          CMD_LSB         = 0;
	localparam int          TRIGGER_BIT     = 2;       // commit_trigger
	localparam int          TADDR_LSB       = 3;
	localparam int          TADDR_W         = 13;
	localparam int          TARGET_BIT      = 30;      // 1 selects egress_tcam_target
	localparam int          WIPE_BIT        = 31;
	localparam logic [1:0]  CMD_WRITE       = 2'h0;    // cache to rule memory
	localparam logic [1:0]  CMD_READ        = 2'h1;    // rule memory to cache

	////////////////////////////////////////////////////////////////////////////////
	// lookup control and status fields
	localparam int          START_BIT       = 0;
	localparam int          LTARGET_BIT     = 1;
	localparam int          DEFIDX_LSB      = 4;
	localparam int          BUSY_BIT        = 31;
	localparam int          HIT_BIT         = 30;
	localparam int          MISS_BIT        = 29;
	localparam int          DEFAULT_BIT     = 28;

	////////////////////////////////////////////////////////////////////////////////
	// tcam geometry
	localparam int          BLOCK_DEPTH     = 1024;
	localparam int          PREFIX_KEY_W    = 36;
	localparam int          PREFIX_RES_W    = 70;
	localparam int          EGRESS_RULES    = 512;
	localparam int          EGRESS_DEFAULTS = 11;
	localparam int          EGRESS_KEY_W    = 30;
	localparam int          EGRESS_RES_W    = 285;
	localparam int          PREFIX_DW       = 2 * PREFIX_KEY_W + PREFIX_RES_W + 1;
	localparam int          EGRESS_DW       = 2 * EGRESS_KEY_W + EGRESS_RES_W + 1;

	typedef enum logic [3:0] {
		ST_IDLE, ST_WIPE, ST_COMMIT, ST_FETCH, ST_LOAD,
		ST_SCAN_REQ, ST_SCAN_CHK, ST_DEF_REQ, ST_COUNT
	} eng_state_type;

endpackage : tcam_prog_pkg

// ### verilog/mem_port_if.sv
`timescale 1ns/1ns
// one port of a rule memory
interface mem_port_if #(
	parameter int AW = 10,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport user  (output we, output addr, output wdata, input rdata);
	modport store (input we, input addr, input wdata, output rdata);
endinterface : mem_port_if

// ### verilog/rule_memory.sv
`timescale 1ns/1ns
module rule_memory #(
	parameter int DEPTH = 512,
	parameter int WIDTH = 8
) (
	input wire logic  sys_clk, // system clock
	input wire logic  rst_n,   // async reset, active low
	mem_port_if.store port     // read/write port
);
	typedef struct packed {
		logic [WIDTH-1:0] rdata;
		logic [DEPTH-1:0] written;
	} state_type;

	state_type        st;
	state_type        next_st;
	logic [WIDTH-1:0] cells [DEPTH];

	if (DEPTH < 1 || DEPTH > (1 << $bits(port.addr)) || WIDTH != $bits(port.wdata))
		$error("rule_memory: depth or width does not fit the port");

	////////////////////////////////////////////////////////////////////////////////
	// never-written cells read as zero, the match-off pattern
	always_comb
	begin
		next_st = st;
		next_st.rdata = (port.addr < DEPTH && st.written[port.addr]) ? cells[port.addr] : '0;
		if (port.we && port.addr < DEPTH)
			next_st.written[port.addr] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	// storage array, no reset
	always_ff @(posedge sys_clk)
	begin
		if (port.we && port.addr < DEPTH)
			cells[port.addr] <= port.wdata;
	end

	assign port.rdata = st.rdata;

endmodule : rule_memory

// ### verilog/tcam_rule_programmer.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Operation
// - prefix tcam gives 1024 addresses per block, 36 entry and 70 action bits each
// - every rule carries a one-bit hit counter that saturates
// - prefix actions carry no tag; full action width holds result data
// - prefix entry bits spread over consecutive addresses after tags; here each address holds and matches its own 36-bit entry, with no tags
// - prefix tcam has no default rules; no match or no blocks is a miss
// - egress tcam owns 512 addresses, 30-bit entry, 285-bit action, single size
// - egress entries and actions carry no tag, mapped directly at offset 0
// - egress tcam has 11 default rules at 512+n, applied on no match
// - cache-wipe bit clears entry, action and counter of the cache
// - offsets not spanned hold match-off, supplied by the cleared cache
// - control write of 4 or address shifted by 3 copies cache to memory
// - after trigger clears the rule is stored and can match
module tcam_rule_programmer
#(
	parameter int PREFIX_BLOCKS = 2 // shared blocks that can be given to the prefix tcam
) (
	input  wire logic                               sys_clk,       // system clock
	input  wire logic                               rst_n,         // async reset, active low
	input  wire logic [tcam_prog_pkg::ADDR_W-1:0]   s_axi_awaddr,  // write address
	input  wire logic                               s_axi_awvalid, // write address valid
	output logic                                    s_axi_awready, // write address ready
	input  wire logic [tcam_prog_pkg::DATA_W-1:0]   s_axi_wdata,   // write data
	input  wire logic [tcam_prog_pkg::DATA_W/8-1:0] s_axi_wstrb,   // byte strobes
	input  wire logic                               s_axi_wvalid,  // write data valid
	output logic                                    s_axi_wready,  // write data ready
	output logic [1:0]                              s_axi_bresp,   // write response
	output logic                                    s_axi_bvalid,  // write response valid
	input  wire logic                               s_axi_bready,  // write response ready
	input  wire logic [tcam_prog_pkg::ADDR_W-1:0]   s_axi_araddr,  // read address
	input  wire logic                               s_axi_arvalid, // read address valid
	output logic                                    s_axi_arready, // read address ready
	output logic [tcam_prog_pkg::DATA_W-1:0]        s_axi_rdata,   // read data
	output logic [1:0]                              s_axi_rresp,   // read response
	output logic                                    s_axi_rvalid,  // read data valid
	input  wire logic                               s_axi_rready   // read data ready
);
	import tcam_prog_pkg::*;

	localparam int PREFIX_DEPTH = PREFIX_BLOCKS * BLOCK_DEPTH;
	localparam int PAW          = $clog2(PREFIX_DEPTH);
	localparam int EAW          = $clog2(EGRESS_RULES + EGRESS_DEFAULTS);

	if (PREFIX_BLOCKS < 1 || PREFIX_BLOCKS > 8)
		$error("tcam_rule_programmer: PREFIX_BLOCKS must be 1 to 8");

	typedef struct packed {
		eng_state_type       eng;
		logic                awHeld;
		logic [ADDR_W-1:0]   awAddr;
		logic                wHeld;
		logic [DATA_W-1:0]   wData;
		logic [3:0]          wStrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [DATA_W-1:0]   rdata;
		logic [63:0]         key;
		logic [63:0]         care;
		logic [287:0]        result;
		logic                counter;
		logic                trigger;
		logic                egress;
		logic [7:0]          blocks;
		logic [63:0]         lkKey;
		logic [3:0]          lkDefault;
		logic                busy;
		logic                hit;
		logic                miss;
		logic                isDefault;
		logic [15:0]         idx;
		logic [15:0]         hitAddr;
	} state_type;

	state_type st;
	state_type next_st;

	mem_port_if #(.AW(PAW), .DW(PREFIX_DW)) prefixPort ();
	mem_port_if #(.AW(EAW), .DW(EGRESS_DW)) egressPort ();

	////////////////////////////////////////////////////////////////////////////////
	// address helpers

	// byte address of word i of a staging array
	function automatic logic [ADDR_W-1:0] wordAt(input logic [ADDR_W-1:0] base, input int i);
		wordAt = base + ADDR_W'(4 * i);
	endfunction : wordAt

	// register contents as software sees them
	function automatic logic [DATA_W-1:0] readReg(input state_type s, input logic [ADDR_W-1:0] a);
		readReg = '0;
		case (a)
			OFS_COMMIT:  readReg = {1'b0, s.egress, 27'h0, s.trigger, 2'h0};
			OFS_BLOCKS:  readReg = {24'h0, s.blocks};
			OFS_LOOKUP:  readReg = {24'h0, s.lkDefault, 2'h0, s.egress, 1'b0};
			OFS_KEY0:    readReg = s.lkKey[31:0];
			OFS_KEY1:    readReg = s.lkKey[63:32];
			OFS_RESULT:  readReg = {s.busy, s.hit, s.miss, s.isDefault, 12'h0, s.hitAddr};
			OFS_COUNTER: readReg = {31'h0, s.counter};
			default:     readReg = '0;
		endcase
		for (int i = 0; i < KEY_WORDS; i++)
		begin
			if (a == wordAt(OFS_KEYW, i))
				readReg = s.key[32*i +: 32];
			if (a == wordAt(OFS_CAREW, i))
				readReg = s.care[32*i +: 32];
		end
		for (int i = 0; i < RES_WORDS; i++)
			if (a == wordAt(OFS_RESW, i))
				readReg = s.result[32*i +: 32];
	endfunction : readReg

	// whether an address names a register
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a <= OFS_COUNTER && a[1:0] == 2'h0);
		if (a >= OFS_KEYW && a < wordAt(OFS_KEYW, KEY_WORDS) && a[1:0] == 2'h0)
			mapped = 1'b1;
		if (a >= OFS_CAREW && a < wordAt(OFS_CAREW, KEY_WORDS) && a[1:0] == 2'h0)
			mapped = 1'b1;
		if (a >= OFS_RESW && a < wordAt(OFS_RESW, RES_WORDS) && a[1:0] == 2'h0)
			mapped = 1'b1;
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////////
	// fields of the rule word just read, for the selected target
	logic [63:0]  rdKey;
	logic [63:0]  rdCare;
	logic [287:0] rdResult;
	logic         rdCounter;
	logic         rdLive;
	logic         rdMatch;
	logic [15:0]  prefixLimit;
	logic         inRange;
	logic [31:0]  merged;

	always_comb
	begin
		if (st.egress)
		begin
			rdKey     = 64'(egressPort.rdata[EGRESS_KEY_W-1:0]);
			rdCare    = 64'(egressPort.rdata[2*EGRESS_KEY_W-1:EGRESS_KEY_W]);
			rdResult  = 288'(egressPort.rdata[EGRESS_DW-2:2*EGRESS_KEY_W]);
			rdCounter = egressPort.rdata[EGRESS_DW-1];
			rdMatch   = ((rdKey[EGRESS_KEY_W-1:0] ^ st.lkKey[EGRESS_KEY_W-1:0])
				& ~rdCare[EGRESS_KEY_W-1:0]) == '0;
		end
		else
		begin
			rdKey     = 64'(prefixPort.rdata[PREFIX_KEY_W-1:0]);
			rdCare    = 64'(prefixPort.rdata[2*PREFIX_KEY_W-1:PREFIX_KEY_W]);
			rdResult  = 288'(prefixPort.rdata[PREFIX_DW-2:2*PREFIX_KEY_W]);
			rdCounter = prefixPort.rdata[PREFIX_DW-1];
			rdMatch   = ((rdKey[PREFIX_KEY_W-1:0] ^ st.lkKey[PREFIX_KEY_W-1:0])
				& ~rdCare[PREFIX_KEY_W-1:0]) == '0;
		end
		rdLive = (rdKey != '0) || (rdCare != '0);
	end

	assign prefixLimit = (st.blocks > 8'(PREFIX_BLOCKS)) ? 16'(PREFIX_DEPTH) : 16'({st.blocks, 10'h0});
	assign inRange     = st.egress ? (st.idx < 16'(EGRESS_RULES + EGRESS_DEFAULTS)) : (st.idx < prefixLimit);

	// strobe merge of the pending write over the current register value
	always_comb
	begin
		merged = readReg(st, st.awAddr);
		for (int b = 0; b < 4; b++)
			if (st.wStrb[b])
				merged[8*b +: 8] = st.wData[8*b +: 8];
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state: bus slave, register writes, then the engine
	always_comb
	begin
		next_st = st;
		if (s_axi_bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (s_axi_rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = readReg(st, s_axi_araddr);
			next_st.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		// a write is carried out once address and data are both held
		if (st.awHeld && st.wHeld)
		begin
			next_st.awHeld = 1'b0;
			next_st.wHeld  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = mapped(st.awAddr) ? RESP_OKAY : RESP_SLVERR;
			case (st.awAddr)
				OFS_COMMIT:
				begin
					if (st.eng == ST_IDLE)
					begin
						if (merged[WIPE_BIT])
						begin
							next_st.trigger = 1'b1;
							next_st.eng     = ST_WIPE;
						end
						else if (merged[TRIGGER_BIT])
						begin
							next_st.trigger = 1'b1;
							next_st.egress  = merged[TARGET_BIT];
							next_st.idx     = 16'(merged[TADDR_LSB +: TADDR_W]);
							next_st.eng     = (merged[CMD_LSB +: 2] == CMD_READ) ? ST_FETCH : ST_COMMIT;
						end
					end
				end
				OFS_BLOCKS:  next_st.blocks = merged[7:0];
				OFS_KEY0:    next_st.lkKey[31:0] = merged;
				OFS_KEY1:    next_st.lkKey[63:32] = merged;
				OFS_COUNTER: next_st.counter = merged[0];
				OFS_LOOKUP:
				begin
					if (st.eng == ST_IDLE && merged[START_BIT])
					begin
						next_st.egress    = merged[LTARGET_BIT];
						next_st.lkDefault = merged[DEFIDX_LSB +: 4];
						next_st.hit       = 1'b0;
						next_st.isDefault = 1'b0;
						next_st.idx       = '0;
						if (!merged[LTARGET_BIT] && st.blocks == '0)
						begin
							next_st.miss = 1'b1;
							next_st.busy = 1'b0;
						end
						else
						begin
							next_st.miss = 1'b0;
							next_st.busy = 1'b1;
							next_st.eng  = ST_SCAN_REQ;
						end
					end
				end
				default: ;
			endcase
			for (int i = 0; i < KEY_WORDS; i++)
			begin
				if (st.awAddr == wordAt(OFS_KEYW, i))
					next_st.key[32*i +: 32] = merged;
				if (st.awAddr == wordAt(OFS_CAREW, i))
					next_st.care[32*i +: 32] = merged;
			end
			for (int i = 0; i < RES_WORDS; i++)
				if (st.awAddr == wordAt(OFS_RESW, i))
					next_st.result[32*i +: 32] = merged;
		end

		// engine
		case (st.eng)
			ST_IDLE: ;
			ST_WIPE:
			begin
				// wipe entry, care, action and counter
				next_st.key     = '0;
				next_st.care    = '0;
				next_st.result  = '0;
				next_st.counter = 1'b0;
				next_st.trigger = 1'b0;
				next_st.eng     = ST_IDLE;
			end
			ST_COMMIT:
			begin
				// word written this cycle, trigger drops next
				next_st.trigger = 1'b0;
				next_st.eng     = ST_IDLE;
			end
			ST_FETCH: next_st.eng = ST_LOAD;
			ST_LOAD:
			begin
				next_st.key     = rdKey;
				next_st.care    = rdCare;
				next_st.result  = rdResult;
				next_st.counter = rdCounter;
				next_st.trigger = 1'b0;
				next_st.eng     = ST_IDLE;
			end
			ST_SCAN_REQ: next_st.eng = ST_SCAN_CHK;
			ST_SCAN_CHK:
			begin
				if (rdLive && rdMatch)
				begin
					next_st.hit     = 1'b1;
					next_st.hitAddr = st.idx;
					next_st.eng     = ST_COUNT;
				end
				else if (st.idx == (st.egress ? 16'(EGRESS_RULES - 1) : prefixLimit - 16'h0001))
				begin
					// egress miss falls to default rule 512+n
					if (st.egress && st.lkDefault < 4'(EGRESS_DEFAULTS))
					begin
						next_st.isDefault = 1'b1;
						next_st.idx       = 16'(EGRESS_RULES) + 16'(st.lkDefault);
						next_st.hitAddr   = 16'(EGRESS_RULES) + 16'(st.lkDefault);
						next_st.eng       = ST_DEF_REQ;
					end
					else
					begin
						next_st.miss = 1'b1;
						next_st.busy = 1'b0;
						next_st.eng  = ST_IDLE;
					end
				end
				else
				begin
					next_st.idx = st.idx + 16'h0001;
					next_st.eng = ST_SCAN_REQ;
				end
			end
			ST_DEF_REQ: next_st.eng = ST_COUNT;
			ST_COUNT:
			begin
				next_st.busy = 1'b0;
				next_st.eng  = ST_IDLE;
			end
			default: next_st.eng = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	// rule memories
	logic memWrite;
	assign memWrite = (st.eng == ST_COMMIT && inRange) || st.eng == ST_COUNT;

	assign prefixPort.we   = memWrite && !st.egress;
	assign prefixPort.addr = st.idx[PAW-1:0];
	// entry, care and action packed per address
	// action stored whole, no tag field
	// count write-back sets the saturating bit
	assign prefixPort.wdata = (st.eng == ST_COUNT) ? {1'b1, prefixPort.rdata[PREFIX_DW-2:0]}
		: {st.counter, st.result[PREFIX_RES_W-1:0], st.care[PREFIX_KEY_W-1:0], st.key[PREFIX_KEY_W-1:0]};

	assign egressPort.we   = memWrite && st.egress;
	assign egressPort.addr = st.idx[EAW-1:0];
	assign egressPort.wdata = (st.eng == ST_COUNT) ? {1'b1, egressPort.rdata[EGRESS_DW-2:0]}
		: {st.counter, st.result[EGRESS_RES_W-1:0], st.care[EGRESS_KEY_W-1:0], st.key[EGRESS_KEY_W-1:0]};

	rule_memory #(.DEPTH(PREFIX_DEPTH), .WIDTH(PREFIX_DW)) prefixMem (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.port    (prefixPort.store)
	);

	rule_memory #(.DEPTH(EGRESS_RULES + EGRESS_DEFAULTS), .WIDTH(EGRESS_DW)) egressMem (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.port    (egressPort.store)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus outputs
	assign s_axi_awready = !st.awHeld && !st.bvalid;
	assign s_axi_wready  = !st.wHeld && !st.bvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fetch_done;
		st.eng == ST_LOAD ##1 (st.eng == ST_IDLE && !st.trigger);
	endsequence

	property p_wipe_clears;
		st.eng == ST_WIPE |=> st.key == '0 && st.care == '0 && st.result == '0 && !st.counter && !st.trigger;
	endproperty
	a_wipe_clears: assert property (p_wipe_clears) else $error("cache not wiped");

	property p_commit_done;
		(st.eng == ST_COMMIT && st.trigger) |=> (!st.trigger && st.eng == ST_IDLE);
	endproperty
	a_commit_done: assert property (p_commit_done) else $error("trigger not cleared after commit");

	property p_fetch_done;
		st.eng == ST_FETCH |=> s_fetch_done;
	endproperty
	a_fetch_done: assert property (p_fetch_done) else $error("read command did not finish");

	property p_commit_writes;
		(st.eng == ST_COMMIT && st.egress && st.idx < 16'(EGRESS_RULES + EGRESS_DEFAULTS))
			|-> egressPort.we && egressPort.wdata[EGRESS_KEY_W-1:0] == st.key[EGRESS_KEY_W-1:0];
	endproperty
	a_commit_writes: assert property (p_commit_writes) else $error("commit did not write cache");

	property p_count_saturates;
		(st.eng == ST_COUNT && !st.egress) |-> prefixPort.we && prefixPort.wdata[PREFIX_DW-1];
	endproperty
	a_count_saturates: assert property (p_count_saturates) else $error("hit counter not set");

	property p_default_addr;
		st.eng == ST_DEF_REQ |-> st.egress && st.isDefault && st.idx == 16'(EGRESS_RULES) + 16'(st.lkDefault);
	endproperty
	a_default_addr: assert property (p_default_addr) else $error("wrong default rule address");

	property p_prefix_no_default;
		(st.eng == ST_SCAN_CHK && !st.egress) |=> !st.isDefault ##1 !st.isDefault;
	endproperty
	a_prefix_no_default: assert property (p_prefix_no_default) else $error("prefix default hit");

	property p_empty_miss;
		(st.awHeld && st.wHeld && st.awAddr == OFS_LOOKUP && st.wStrb[0] && st.wData[START_BIT]
			&& !st.wData[LTARGET_BIT] && st.blocks == '0 && st.eng == ST_IDLE) |=> st.miss && !st.busy;
	endproperty
	a_empty_miss: assert property (p_empty_miss) else $error("no-block lookup not a miss");

endmodule : tcam_rule_programmer

// ### verification/tcam_rule_programmer_tb.sv
`timescale 1ns/1ns
module tcam_rule_programmer_tb;
	import tcam_prog_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] s;} row_type;
	logic        sys_clk       = 1'b0;
	logic        rst_n         = 1'b0;
	logic [11:0] s_axi_awaddr  = 12'h000;
	logic [11:0] s_axi_araddr  = 12'h000;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_bready  = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready  = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          nMismatch     = 0;
	int          checked       = 0;
	// readback rows: address, written word, expected word, expected response
	row_type     rows[5]       = '{'{OFS_KEYW, 32'hA5A5A5A5, 32'hA5A5A5A5, RESP_OKAY},
		'{OFS_CAREW, 32'h0000FFFF, 32'h0000FFFF, RESP_OKAY}, '{OFS_RESW + 12'h020, 32'h12345678, 32'h12345678, RESP_OKAY},
		'{12'h100, 32'hFFFFFFFF, 32'h00000000, RESP_SLVERR}, '{OFS_BLOCKS, 32'h000000FF, 32'h000000FF, RESP_OKAY}};

	tcam_rule_programmer tcam_rule_programmer_inst (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	////////////////////////////////////////////////////////////////////////////////
	// clock, compare and closing
	initial forever #20 sys_clk = ~sys_clk;

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			nMismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task conclude;
		$display("checked=%0d nMismatch=%0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// bus tasks: ready sampled at the falling edge, released after the taking edge
	task wr(input logic [11:0] a, input logic [31:0] v);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw))
		begin
			@(negedge sys_clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge sys_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task rd(input logic [11:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask : rd

	// read until a status bit drops, bounded
	task poll(input logic [11:0] a, input int b);
		int k;
		d = 32'hFFFFFFFF;
		for (k = 0; k < 3000 && d[b] !== 1'b0; k++) rd(a);
		chk({31'h0, d[b]}, 32'h0);
	endtask : poll

	// load a lookup key, start a lookup and wait until it ends
	task look(input logic [31:0] k, input logic [31:0] c);
		wr(OFS_KEY0, k);
		wr(OFS_LOOKUP, c);
		poll(OFS_RESULT, BUSY_BIT);
	endtask : look

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the few thousand cycles the sequence needs
	initial
	begin
		#2000000;
		nMismatch++;
		conclude();
	end

	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFS_RESULT);
		chk(d, 32'h0);
		// table of register readbacks, unmapped place included
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			chk({30'h0, r}, {30'h0, rows[i].s});
			rd(rows[i].a);
			chk(d, rows[i].e);
			chk({30'h0, r}, {30'h0, rows[i].s});
		end
		// wipe empties the staged words
		wr(OFS_COMMIT, 32'h80000000);
		poll(OFS_COMMIT, TRIGGER_BIT);
		rd(OFS_KEYW);
		chk(d, 32'h0);
		rd(OFS_RESW + 12'h020);
		chk(d, 32'h0);
		// prefix lookup with no blocks misses
		wr(OFS_BLOCKS, 32'h0);
		wr(OFS_LOOKUP, 32'h1);
		poll(OFS_RESULT, BUSY_BIT);
		chk(32'(d[31:28]), 32'h2);
		// egress default index 3 takes 515, index 11 misses
		wr(OFS_LOOKUP, 32'h33);
		poll(OFS_RESULT, BUSY_BIT);
		chk(d, 32'h10000203);
		wr(OFS_LOOKUP, 32'hB3);
		poll(OFS_RESULT, BUSY_BIT);
		chk(32'(d[31:28]), 32'h2);
		// stage an egress rule, commit to address 5, then look it up twice
		wr(OFS_KEYW, 32'h2ABCDEF1);
		wr(OFS_COMMIT, 32'h4000002C);
		poll(OFS_COMMIT, TRIGGER_BIT);
		wr(OFS_KEY0, 32'h2ABCDEF1);
		repeat (2)
		begin
			wr(OFS_LOOKUP, 32'h3);
			poll(OFS_RESULT, BUSY_BIT);
			chk(d, 32'h40000005);
		end
		// fetch address 5 back: counter held at one after two hits
		wr(OFS_COMMIT, 32'h4000002D);
		poll(OFS_COMMIT, TRIGGER_BIT);
		rd(OFS_COUNTER);
		chk(d, 32'h1);
		rd(OFS_KEYW);
		chk(d, 32'h2ABCDEF1);
		// prefix one-address rules at 8 and 9: top offset first, each key matched whole at its own address, no tags
		wr(OFS_COMMIT, 32'h80000000);
		poll(OFS_COMMIT, TRIGGER_BIT);
		wr(OFS_BLOCKS, 32'h1);
		wr(OFS_CAREW, 32'h0);
		wr(OFS_KEYW, 32'h00000246);
		wr(OFS_COMMIT, 32'h0000004C);
		poll(OFS_COMMIT, TRIGGER_BIT);
		wr(OFS_KEYW, 32'h0000048E);
		wr(OFS_COMMIT, 32'h00000044);
		poll(OFS_COMMIT, TRIGGER_BIT);
		look(32'h0000048E, 32'h1);
		chk(d, 32'h40000008);
		look(32'h00000246, 32'h1);
		chk(d, 32'h40000009);
		look(32'h00000007, 32'h1);
		chk(32'(d[31:28]), 32'h2);
		// reset in mid-run: registers and rule memories come back empty
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(OFS_BLOCKS);
		chk(d, 32'h0);
		wr(OFS_COMMIT, 32'h4000002D);
		poll(OFS_COMMIT, TRIGGER_BIT);
		rd(OFS_KEYW);
		chk(d, 32'h0);
		conclude();
	end
endmodule : tcam_rule_programmer_tb
